// File: core/wdp_watchdog.sv
// watchdog timer with postscaler, normal timer mode and power-up timer
`timescale 1ns/1ps

// Notes on behaviour
// - counts own RC ticks, also during sleep
// - watchdog time-out resets device, awake or asleep
// - select code 00 disables watchdog while it is selected
// - ratio one times out after about 12 ms
// - postscaler lengthens time-out up to 1:256
// - clear or sleep instruction zeroes counter, postscaler
// - watchdog time-out clears active-low time-out flag
// - held clear in reset, cleared on interrupt wake
// - counting starts first edge after reset release
// - counter doubles as power-up delay timer
// - timer mode counts the device clock
// - timer mode overflows after 65536 device clocks
// - timer overflow clears flag, no device reset
// - clear instruction sets time-out flag again
// - timer mode stops counting during sleep
// - counter and postscaler not software accessible
module wdp_watchdog #(
    parameter int RC_PERIOD_NS = wdp_pkg::CLK_PERIOD_NS,
    parameter int BASE_TICKS   = wdp_pkg::WDT_TIMEOUT_NS / RC_PERIOD_NS,
    parameter int TIMER_OVF    = wdp_pkg::TIMER_OVF_TOSC
) (
    input  wire logic             sys_clk,
    input  wire logic             sys_rst,
    input  wire logic             rc_tick,
    input  wire logic [1:0]       wdt_period_select,
    input  wire wdp_pkg::wdp_ctl_t  ctl_i,
    output wdp_pkg::wdp_stat_t      stat_o
);
    import wdp_pkg::*;

    // ==========================================================
    // derived limits
    localparam logic [CNT_W-1:0] BASE_LAST  = CNT_W'(BASE_TICKS - 1);
    localparam logic [CNT_W-1:0] TIMER_LAST = CNT_W'(TIMER_OVF - 1);

    // postscaler end value per select code
    function automatic logic [POST_W-1:0] post_last(input logic [1:0] sel);
        if (sel == PSEL_P256) begin
            return POST_LAST_256;
        end else begin
            return POST_LAST_1;
        end
    endfunction

    wdp_state_t st_q;
    wdp_state_t st_d;
    logic       clr_evt;

    // the sleep instruction, clear instruction, device reset and wake all restart it
    assign clr_evt = ctl_i.dev_reset | ctl_i.clear_watchdog_instr
                   | ctl_i.sleep_instr | ctl_i.wake_irq;

    // ==========================================================
    // next state
    always_comb begin
        st_d = st_q;
        st_d.stat.wdt_reset = 1'b0;
        st_d.stat.timer_ovf = 1'b0;
        case (st_q.mode)
            ST_PWRUP: begin
                if (rc_tick) begin
                    if (st_q.cnt == BASE_LAST) begin
                        st_d.cnt = CNT_RST;
                        st_d.post = POST_RST;
                        st_d.mode = ST_RUN;
                        st_d.stat.pwrup_done = 1'b1;
                    end else begin
                        st_d.cnt = st_q.cnt + 1'b1;
                    end
                end
            end
            default: begin
                if (clr_evt) begin
                    st_d.cnt = CNT_RST;
                    st_d.post = POST_RST;
                    if (ctl_i.clear_watchdog_instr) begin
                        st_d.stat.timeout_flag_n = 1'b1;
                    end
                end else if (wdt_period_select == PSEL_TIMER) begin
                    if (!ctl_i.sleep_mode) begin
                        if (st_q.cnt == TIMER_LAST) begin
                            st_d.cnt = CNT_RST;
                            st_d.stat.timer_ovf = 1'b1;
                            st_d.stat.timeout_flag_n = 1'b0;
                        end else begin
                            st_d.cnt = st_q.cnt + 1'b1;
                        end
                    end
                end else if (wdt_period_select != PSEL_OFF && rc_tick) begin
                    // sleep does not stop the RC tick count
                    if (st_q.cnt == BASE_LAST) begin
                        st_d.cnt = CNT_RST;
                        if (st_q.post == post_last(wdt_period_select)) begin
                            st_d.post = POST_RST;
                            st_d.stat.wdt_reset = 1'b1;
                            st_d.stat.timeout_flag_n = 1'b0;
                        end else begin
                            st_d.post = st_q.post + 1'b1;
                        end
                    end else begin
                        st_d.cnt = st_q.cnt + 1'b1;
                    end
                end
            end
        endcase
    end

    // ==========================================================
    // state register; no software path reaches cnt or post
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            st_q.mode <= ST_PWRUP;
            st_q.cnt <= CNT_RST;
            st_q.post <= POST_RST;
            st_q.stat.wdt_reset <= 1'b0;
            st_q.stat.timeout_flag_n <= 1'b1;
            st_q.stat.pwrup_done <= 1'b0;
            st_q.stat.timer_ovf <= 1'b0;
        end else begin
            st_q <= st_d;
        end
    end

    assign stat_o = st_q.stat;

    // ==========================================================
    // assertions
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);

    a_clear_restarts: assert property (
        (st_q.mode == ST_RUN && (ctl_i.clear_watchdog_instr || ctl_i.sleep_instr))
        |=> (st_q.cnt == CNT_RST && st_q.post == POST_RST))
        else $error("clear did not restart counter");

    a_reset_holds_clear: assert property (
        (st_q.mode == ST_RUN && (ctl_i.dev_reset || ctl_i.wake_irq))
        |=> st_q.cnt == CNT_RST)
        else $error("counter not held clear");

    a_first_edge_count: assert property (
        (st_q.mode == ST_RUN && $past(ctl_i.dev_reset) && !clr_evt
         && wdt_period_select == PSEL_TIMER && !ctl_i.sleep_mode)
        |=> st_q.cnt == CNT_W'(1))
        else $error("count did not start after reset");

    a_timeout_flag: assert property (
        st_q.stat.wdt_reset |-> !st_q.stat.timeout_flag_n)
        else $error("flag not cleared on time-out");

    a_disabled_quiet: assert property (
        (wdt_period_select == PSEL_OFF && $past(wdt_period_select) == PSEL_OFF)
        |=> !st_q.stat.wdt_reset)
        else $error("disabled watchdog reset");

    a_ratio_one: assert property (
        (st_q.stat.wdt_reset && $past(wdt_period_select) == PSEL_P1)
        |-> $past(st_q.cnt) == BASE_LAST && $past(rc_tick))
        else $error("time-out at wrong count");

    a_rc_in_sleep: assert property (
        (st_q.mode == ST_RUN && !clr_evt && rc_tick && ctl_i.sleep_mode
         && wdt_period_select == PSEL_P256 && st_q.cnt != BASE_LAST)
        |=> st_q.cnt == $past(st_q.cnt) + 1'b1)
        else $error("counter stalled in sleep");

    a_timer_ovf: assert property (
        st_q.stat.timer_ovf |-> $past(st_q.cnt) == TIMER_LAST
                              && !st_q.stat.wdt_reset && !st_q.stat.timeout_flag_n)
        else $error("bad timer overflow");

    a_timer_sleep: assert property (
        (st_q.mode == ST_RUN && !clr_evt && ctl_i.sleep_mode
         && wdt_period_select == PSEL_TIMER)
        |=> st_q.cnt == $past(st_q.cnt))
        else $error("timer counted in sleep");

    a_flag_set: assert property (
        (st_q.mode == ST_RUN && ctl_i.clear_watchdog_instr)
        |=> st_q.stat.timeout_flag_n)
        else $error("flag not set by clear");

    a_pwrup_order: assert property (
        (st_q.mode == ST_PWRUP) |-> !st_q.stat.pwrup_done && !st_q.stat.wdt_reset)
        else $error("power-up timer state wrong");

    // ==========================================================
    // power-up timer checks
    a_pwrup_step: assert property (
        (st_q.mode == ST_PWRUP && rc_tick
         && st_q.cnt != BASE_LAST)
        |=> st_q.mode == ST_PWRUP && st_q.cnt == $past(st_q.cnt) + 1'b1)
        else $error("power-up count did not step");

    a_pwrup_hold: assert property (
        (st_q.mode == ST_PWRUP
         && !rc_tick)
        |=> st_q.cnt == $past(st_q.cnt))
        else $error("power-up count moved without tick");

    a_pwrup_end: assert property (
        (st_q.mode == ST_PWRUP && rc_tick
         && st_q.cnt == BASE_LAST)
        |=> st_q.mode == ST_RUN && st_q.stat.pwrup_done && st_q.cnt == CNT_RST)
        else $error("power-up delay did not end");

    a_pwrup_quiet: assert property (
        (st_q.mode == ST_PWRUP)
        |-> st_q.stat.timeout_flag_n
            && !st_q.stat.timer_ovf)
        else $error("status moved during power-up");

    a_done_sticks: assert property (
        st_q.stat.pwrup_done
        |=>
        st_q.stat.pwrup_done)
        else $error("power-up done fell");

    a_run_after_done: assert property (
        (st_q.mode == ST_RUN)
        |->
        st_q.stat.pwrup_done)
        else $error("running before power-up end");

    // ==========================================================
    // watchdog mode checks
    a_wd_needs_tick: assert property (
        (st_q.mode == ST_RUN && !clr_evt && !rc_tick
         && (wdt_period_select == PSEL_P1 || wdt_period_select == PSEL_P256))
        |=> st_q.cnt == $past(st_q.cnt))
        else $error("watchdog counted without tick");

    a_wd_no_ovf: assert property (
        (wdt_period_select != PSEL_TIMER)
        |=>
        !st_q.stat.timer_ovf)
        else $error("timer overflow outside timer mode");

    a_p256_step: assert property (
        (st_q.mode == ST_RUN && !clr_evt && rc_tick && wdt_period_select == PSEL_P256
         && st_q.cnt == BASE_LAST && st_q.post != POST_LAST_256)
        |=> st_q.post == $past(st_q.post) + 1'b1 && st_q.cnt == CNT_RST)
        else $error("postscaler did not step");

    a_p256_last: assert property (
        (st_q.stat.wdt_reset
         && $past(wdt_period_select) == PSEL_P256)
        |-> $past(st_q.post) == POST_LAST_256)
        else $error("long time-out too early");

    a_timeout_restart: assert property (
        st_q.stat.wdt_reset
        |-> st_q.cnt == CNT_RST
            && st_q.post == POST_RST)
        else $error("time-out did not restart count");

    a_off_holds: assert property (
        (st_q.mode == ST_RUN && !clr_evt
         && wdt_period_select == PSEL_OFF)
        |=> st_q.cnt == $past(st_q.cnt) && st_q.post == $past(st_q.post))
        else $error("disabled watchdog counted");

    a_off_keeps_flag: assert property (
        (st_q.mode == ST_RUN && st_q.stat.timeout_flag_n
         && wdt_period_select == PSEL_OFF)
        |=> st_q.stat.timeout_flag_n)
        else $error("disabled watchdog cleared flag");

    // ==========================================================
    // timer mode checks
    a_timer_counts: assert property (
        (st_q.mode == ST_RUN && !clr_evt && !ctl_i.sleep_mode
         && wdt_period_select == PSEL_TIMER && st_q.cnt != TIMER_LAST)
        |=> st_q.cnt == $past(st_q.cnt) + 1'b1)
        else $error("timer did not count clock");

    a_timer_no_reset: assert property (
        (wdt_period_select == PSEL_TIMER)
        |=>
        !st_q.stat.wdt_reset)
        else $error("timer mode reset device");

    a_timer_no_post: assert property (
        (st_q.mode == ST_RUN && !clr_evt
         && wdt_period_select == PSEL_TIMER)
        |=> st_q.post == $past(st_q.post))
        else $error("timer mode moved postscaler");

    a_ovf_wraps: assert property (
        st_q.stat.timer_ovf
        |->
        st_q.cnt == CNT_RST)
        else $error("timer did not wrap");

    a_ovf_single: assert property (
        st_q.stat.timer_ovf
        |=>
        !st_q.stat.timer_ovf)
        else $error("overflow pulse too long");

    // ==========================================================
    // clear and flag checks
    a_wake_clears_post: assert property (
        (st_q.mode == ST_RUN
         && ctl_i.wake_irq)
        |=> st_q.post == POST_RST)
        else $error("wake did not clear postscaler");

    a_dev_holds_post: assert property (
        (st_q.mode == ST_RUN
         && ctl_i.dev_reset)
        |=> st_q.post == POST_RST)
        else $error("reset did not clear postscaler");

    a_clear_no_pulse: assert property (
        (st_q.mode == ST_RUN
         && clr_evt)
        |=> !st_q.stat.wdt_reset && !st_q.stat.timer_ovf)
        else $error("expiry despite clear");

    a_flag_holds_low: assert property (
        (st_q.mode == ST_RUN && !st_q.stat.timeout_flag_n
         && !ctl_i.clear_watchdog_instr)
        |=> !st_q.stat.timeout_flag_n)
        else $error("flag set without clear");

    a_flag_fall_cause: assert property (
        (st_q.stat.timeout_flag_n
         ##1 !st_q.stat.timeout_flag_n)
        |-> st_q.stat.wdt_reset || st_q.stat.timer_ovf)
        else $error("flag fell without expiry");

    c_wdt_reset: cover property (st_q.stat.wdt_reset && ctl_i.sleep_mode);
    c_timer_ovf: cover property (st_q.stat.timer_ovf);
    c_pwrup_done: cover property ($rose(st_q.stat.pwrup_done));
    c_clear_flag: cover property (!st_q.stat.timeout_flag_n ##1 st_q.stat.timeout_flag_n);
    c_dev_restart: cover property (st_q.mode == ST_RUN && ctl_i.dev_reset);
endmodule

// File: pkg/wdp_pkg.sv
// shared types and constants for the watchdog with postscaler
package wdp_pkg;

    // ==========================================================
    // clock and timing
    localparam int CLK_PERIOD_NS   = 40;
    localparam int WDT_TIMEOUT_NS  = 12_000_000;
    localparam int TIMER_OVF_TOSC  = 65536;
    localparam int CNT_W           = 20;
    localparam int POST_W          = 8;

    // ==========================================================
    // period select configuration codes
    localparam logic [1:0] PSEL_OFF   = 2'h0;
    localparam logic [1:0] PSEL_TIMER = 2'h1;
    localparam logic [1:0] PSEL_P256  = 2'h2;
    localparam logic [1:0] PSEL_P1    = 2'h3;

    // last postscaler value before a time-out
    localparam logic [POST_W-1:0] POST_LAST_256 = 8'hFF;
    localparam logic [POST_W-1:0] POST_LAST_1   = 8'h00;

    // ==========================================================
    // reset values
    localparam logic [CNT_W-1:0]  CNT_RST  = 20'h00000;
    localparam logic [POST_W-1:0] POST_RST = 8'h00;

    // ==========================================================
    // carriers
    typedef enum logic {
        ST_PWRUP,
        ST_RUN
    } wdp_mode_t;

    typedef struct packed {
        logic dev_reset;
        logic clear_watchdog_instr;
        logic sleep_instr;
        logic wake_irq;
        logic sleep_mode;
    } wdp_ctl_t;

    typedef struct packed {
        logic wdt_reset;
        logic timeout_flag_n;
        logic pwrup_done;
        logic timer_ovf;
    } wdp_stat_t;

    typedef struct packed {
        wdp_mode_t         mode;
        logic [CNT_W-1:0]  cnt;
        logic [POST_W-1:0] post;
        wdp_stat_t         stat;
    } wdp_state_t;

endpackage

// File: tb/wdp_watchdog_bench.sv
// self-checking bench for the watchdog with postscaler
`timescale 1ns/1ps
module wdp_watchdog_bench;
    import wdp_pkg::*;
    // ==========================================================
    // shortened counts and event codes
    localparam int       BT   = 8;
    localparam int       OVF  = 16;
    localparam wdp_ctl_t DEV  = 5'h10;
    localparam wdp_ctl_t CLR  = 5'h08;
    localparam wdp_ctl_t SLP  = 5'h04;
    localparam wdp_ctl_t WAKE = 5'h02;
    localparam wdp_ctl_t ASLP = 5'h01;
    localparam wdp_ctl_t EV [4] = '{CLR, SLP, WAKE, DEV};
    logic       sys_clk = 1'b0;
    logic       sys_rst = 1'b1;
    logic       rc_tick = 1'b0;
    logic [1:0] wdt_period_select = PSEL_P1;
    wdp_ctl_t   ctl_i = '0;
    wdp_ctl_t   lvl = '0;
    wdp_stat_t  stat_o;
    int         n_mismatch = 0;
    int         n_compared = 0;
    int         n_rst = 0;
    int         n_ovf = 0;

    wdp_watchdog #(.BASE_TICKS(BT), .TIMER_OVF(OVF)) wdp_watchdog_i (
        .sys_clk           (sys_clk),
        .sys_rst           (sys_rst),
        .rc_tick           (rc_tick),
        .wdt_period_select (wdt_period_select),
        .ctl_i             (ctl_i),
        .stat_o            (stat_o)
    );

    initial begin
        forever #20 sys_clk = ~sys_clk;
    end

    // ==========================================================
    // helpers
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t saw %0h expected %0h", $time, seen, exp);
        end
    endtask

    // one edge: drive, then count pulses launched by the previous inputs
    task cyc(input logic t, input wdp_ctl_t c);
        @(posedge sys_clk);
        rc_tick <= t;
        ctl_i   <= wdp_ctl_t'(c | lvl);
        #1;
        if (stat_o.wdt_reset === 1'b1) n_rst++;
        if (stat_o.timer_ovf === 1'b1) n_ovf++;
    endtask

    task tick(input int n);
        repeat (n) begin
            cyc(1'b1, '0);
            cyc(1'b0, '0);
        end
    endtask

    task idle(input int n);
        repeat (n) cyc(1'b0, '0);
    endtask

    task pulse(input wdp_ctl_t c);
        cyc(1'b0, c);
        cyc(1'b0, '0);
        n_rst = 0;
        n_ovf = 0;
    endtask

    task sel(input logic [1:0] v);
        @(posedge sys_clk);
        wdt_period_select <= v;
    endtask

    // ==========================================================
    // scenarios
    task sc_pwrup;
        repeat (4) @(posedge sys_clk);
        sys_rst <= 1'b0;
        #1;
        chk(stat_o, 4'h4);
        tick(BT - 1);
        chk(stat_o.pwrup_done, 1'b0);
        tick(1);
        chk(stat_o.pwrup_done, 1'b1);
    endtask

    task sc_ratio1;
        pulse(CLR);
        tick(BT - 1);
        chk(n_rst, 0);
        tick(1);
        chk(stat_o.wdt_reset, 1'b1);
        chk(stat_o.timeout_flag_n, 1'b0);
        idle(1);
        chk(stat_o.wdt_reset, 1'b0);
        pulse(CLR);
        chk(stat_o.timeout_flag_n, 1'b1);
        lvl = ASLP;
        pulse(SLP);
        tick(BT);
        chk(n_rst, 1);
        lvl = '0;
    endtask

    task sc_clear;
        for (int i = 0; i < 4; i++) begin
            pulse(CLR);
            tick(BT - 2);
            pulse(EV[i]);
            tick(BT - 1);
            chk(n_rst, 0);
            tick(1);
            chk(n_rst, 1);
        end
    endtask

    task sc_off_p256;
        sel(PSEL_OFF);
        pulse(CLR);
        tick(3 * BT);
        chk(n_rst, 0);
        sel(PSEL_P256);
        pulse(CLR);
        tick(256 * BT - 1);
        chk(n_rst, 0);
        tick(1);
        chk(stat_o.wdt_reset, 1'b1);
    endtask

    task sc_timer;
        sel(PSEL_TIMER);
        pulse(CLR);
        pulse(DEV);
        idle(OVF - 1);
        chk(n_ovf, 0);
        idle(1);
        chk(stat_o.timer_ovf, 1'b1);
        chk(stat_o.timeout_flag_n, 1'b0);
        idle(2 * OVF);
        chk(n_rst, 0);
        pulse(CLR);
        chk(stat_o.timeout_flag_n, 1'b1);
        lvl = ASLP;
        pulse(CLR);
        idle(3 * OVF);
        chk(n_ovf, 0);
        lvl = '0;
        idle(OVF + 1);
        chk(n_ovf, 1);
    endtask

    task test_done;
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        sc_pwrup;
        sc_ratio1;
        sc_clear;
        sc_off_p256;
        sc_timer;
        test_done;
    end

    // hang guard
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_mismatch++;
        test_done;
    end
endmodule
